// file: lsmc_pkg.sv
// Constants and types for the LIN mode controller
package lsmc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int DOM_TIMEOUT_NS = 6000000;
	localparam int DOM_CLEAR_NS   = 10000;
	localparam int RESET_DELAY_NS = 10000000;
	localparam int MODE_SEL_NS    = 3200;
	localparam int BUS_WAKE_NS    = 100000;
	localparam int PIN_WAKE_NS    = 200000;
	localparam int WDOG_NS        = 20000000;
	// Least times round up to whole cycles
	localparam int DOM_TIMEOUT_CYC =
		(DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DOM_CLEAR_CYC   =
		(DOM_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_DELAY_CYC =
		(RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_SEL_CYC    =
		(MODE_SEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUS_WAKE_CYC    =
		(BUS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_WAKE_CYC    =
		(PIN_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDOG_CYC        = WDOG_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CTRL   = 4'h4;
	localparam int CTRL_LOCAL_WAKE_BIT = 0;
	localparam int CTRL_BUS_WAKE_BIT   = 1;
	localparam logic [1:0] CTRL_RESET  = 2'h3;
	localparam int ST_DOM_BIT  = 3;
	localparam int ST_WREQ_BIT = 4;
	localparam int ST_WSRC_BIT = 5;
	localparam int ST_RST_BIT  = 6;
	localparam int ST_DBG_BIT  = 7;

	typedef enum logic [2:0] {
		MODE_UNPOWERED,
		MODE_PRENORMAL,
		MODE_NORMAL,
		MODE_SELECT,
		MODE_SILENT,
		MODE_SLEEP
	} lsmc_mode_e;

endpackage : lsmc_pkg

// file: lsmc_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module lsmc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	// Pins in, synchronised levels out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= pin_in;
			sync_out <= meta_ff;
		end
	end

endmodule : lsmc_sync

// file: lsmc_timer.sv
// Saturating run-time counter with a done level
`timescale 1ns/1ps
module lsmc_timer #(
	parameter int CYCLES = 1
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// Count while run is high, clear when it drops
	input  wire logic run,
	output logic      done
);

	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LIMIT = W'(CYCLES);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	assign nxt_cnt = !run ? '0 :
		(cnt_ff == LIMIT) ? cnt_ff : cnt_ff + 1'b1;
	assign done = run && (cnt_ff == LIMIT);

	always_ff @(posedge core_clk)
	begin
		if (reset)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

endmodule : lsmc_timer

// file: lsmc_mode_ctrl.sv
// Operating-mode controller of a LIN system-basis chip
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lsmc_mode_ctrl #(
	parameter int DOM_TIMEOUT_CYC = lsmc_pkg::DOM_TIMEOUT_CYC,
	parameter int RESET_DELAY_CYC = lsmc_pkg::RESET_DELAY_CYC,
	parameter int BUS_WAKE_CYC    = lsmc_pkg::BUS_WAKE_CYC,
	parameter int PIN_WAKE_CYC    = lsmc_pkg::PIN_WAKE_CYC,
	parameter int WDOG_CYC        = lsmc_pkg::WDOG_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Controller pins
	input  wire logic        enable,
	input  wire logic        tx_in,
	input  wire logic        trigger_rise,
	input  wire logic        trigger_fall,
	input  wire logic        debug_sel,
	output logic             tx_out,
	output logic             tx_oe,
	output logic             rx_out,
	output logic             reset_out_n,
	// Bus and supply side
	input  wire logic        bus_in,
	input  wire logic        wake_n,
	input  wire logic        vs_present,
	input  wire logic        vs_low,
	input  wire logic        vdd_undervolt,
	output logic             bus_drive_dom,
	output logic             term_en,
	output logic             reg_en,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pins_s;
	logic       en_s, tx_s, bus_s, wake_s, trr_s, trf_s;
	logic       dbg_s, vsp_s, vsl_s, uv_s;

	lsmc_sync #(.WIDTH(10)) u_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.pin_in   ({vdd_undervolt, vs_low, vs_present, debug_sel,
			trigger_fall, trigger_rise, wake_n, bus_in, tx_in,
			enable}),
		.sync_out ({uv_s, vsl_s, vsp_s, dbg_s, pins_s[5:0]})
	);
	assign {trf_s, trr_s, wake_s, bus_s, tx_s, en_s} = pins_s[5:0];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	lsmc_pkg::lsmc_mode_e mode_ff, nxt_mode;
	logic       en_d_ff, trr_d_ff, trf_d_ff, bus_arm_ff;
	logic       dom_to_ff, rst_hold_ff, wreq_ff, wsrc_bus_ff;
	logic [1:0] ctrl_ff;
	logic       nxt_dom_to, nxt_rst_hold, nxt_wreq, nxt_wsrc_bus;
	logic       nxt_bus_arm;
	logic       dom_done, rec_done, rst_done, bwake_done, pwake_done;
	logic       msel_done, wd_done;
	logic       rst_set;

	wire in_normal = (mode_ff == lsmc_pkg::MODE_NORMAL);
	wire in_pre    = (mode_ff == lsmc_pkg::MODE_PRENORMAL);
	wire in_silent = (mode_ff == lsmc_pkg::MODE_SILENT);
	wire in_sleep  = (mode_ff == lsmc_pkg::MODE_SLEEP);
	wire in_low    = in_silent || in_sleep;
	wire en_fall   = en_d_ff && !en_s;
	wire trig_evt  = (trr_s && !trr_d_ff) || (!trf_s && trf_d_ff);
	wire bus_wake  = bwake_done && ctrl_ff[lsmc_pkg::CTRL_BUS_WAKE_BIT];
	wire pin_wake  = pwake_done &&
		ctrl_ff[lsmc_pkg::CTRL_LOCAL_WAKE_BIT];
	// Watchdog only while the regulator feeds a running controller
	wire wd_active = (in_pre || in_normal) && !rst_hold_ff && !dbg_s;

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	lsmc_timer #(.CYCLES(DOM_TIMEOUT_CYC)) u_dom (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (in_normal && !tx_s),
		.done     (dom_done)
	);
	lsmc_timer #(.CYCLES(lsmc_pkg::DOM_CLEAR_CYC)) u_rec (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (dom_to_ff && tx_s),
		.done     (rec_done)
	);
	lsmc_timer #(.CYCLES(RESET_DELAY_CYC)) u_rst (
		.core_clk (core_clk),
		.reset    (reset),
		// Counts from the last cause, so Unpowered time gives no credit
		.run      (rst_hold_ff && !rst_set && !uv_s),
		.done     (rst_done)
	);
	lsmc_timer #(.CYCLES(lsmc_pkg::MODE_SEL_CYC)) u_msel (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (mode_ff == lsmc_pkg::MODE_SELECT),
		.done     (msel_done)
	);
	// Bus wake needs a falling edge: armed only by a recessive level
	lsmc_timer #(.CYCLES(BUS_WAKE_CYC)) u_bwake (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (in_low && bus_arm_ff && !bus_s),
		.done     (bwake_done)
	);
	lsmc_timer #(.CYCLES(PIN_WAKE_CYC)) u_pwake (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (in_low && !wake_s),
		.done     (pwake_done)
	);
	lsmc_timer #(.CYCLES(WDOG_CYC)) u_wdog (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (wd_active && !trig_evt),
		.done     (wd_done)
	);

	// ----------------------------------------------------------------
	// Mode state machine
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_mode = mode_ff;
		if (!vsp_s)
			nxt_mode = lsmc_pkg::MODE_UNPOWERED;
		else
		begin
			case (mode_ff)
				lsmc_pkg::MODE_UNPOWERED:
					nxt_mode = lsmc_pkg::MODE_PRENORMAL;
				lsmc_pkg::MODE_PRENORMAL:
					if (en_s && !rst_hold_ff)
						nxt_mode = lsmc_pkg::MODE_NORMAL;
				lsmc_pkg::MODE_NORMAL:
					if (uv_s)
						nxt_mode = lsmc_pkg::MODE_PRENORMAL;
					else if (en_fall)
						nxt_mode = lsmc_pkg::MODE_SELECT;
				lsmc_pkg::MODE_SELECT:
					// Tolerates TX falling shortly after enable
					if (en_s)
						nxt_mode = lsmc_pkg::MODE_NORMAL;
					else if (msel_done && tx_s)
						nxt_mode = lsmc_pkg::MODE_SILENT;
					else if (msel_done)
						nxt_mode = lsmc_pkg::MODE_SLEEP;
				lsmc_pkg::MODE_SILENT:
					if (uv_s || vsl_s || bus_wake || pin_wake)
						nxt_mode = lsmc_pkg::MODE_PRENORMAL;
					else if (en_s)
						nxt_mode = lsmc_pkg::MODE_NORMAL;
				lsmc_pkg::MODE_SLEEP:
					// Enable alone cannot end Sleep
					if (vsl_s || bus_wake || pin_wake)
						nxt_mode = lsmc_pkg::MODE_PRENORMAL;
				default:
					nxt_mode = lsmc_pkg::MODE_PRENORMAL;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	assign nxt_dom_to = dom_done || (dom_to_ff && !rec_done);
	// Sleep lets the regulator fall with no undervoltage reset
	assign rst_set = !in_sleep && (
		(mode_ff == lsmc_pkg::MODE_UNPOWERED) || uv_s || wd_done ||
		(in_low && vsl_s));
	assign nxt_rst_hold = rst_set || (rst_hold_ff && !rst_done);
	wire wake_set = in_low && (bus_wake || pin_wake);
	assign nxt_wreq = wake_set || (wreq_ff && !(in_pre && en_s));
	assign nxt_wsrc_bus = wake_set ? bus_wake :
		(wsrc_bus_ff && !(in_pre && en_s));
	assign nxt_bus_arm = in_low && (bus_s || bus_arm_ff);

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			mode_ff     <= lsmc_pkg::MODE_UNPOWERED;
			en_d_ff     <= 1'b0;
			trr_d_ff    <= 1'b0;
			trf_d_ff    <= 1'b0;
			bus_arm_ff  <= 1'b0;
			dom_to_ff   <= 1'b0;
			rst_hold_ff <= 1'b1;
			wreq_ff     <= 1'b0;
			wsrc_bus_ff <= 1'b0;
		end
		else
		begin
			mode_ff     <= nxt_mode;
			en_d_ff     <= en_s;
			trr_d_ff    <= trr_s;
			trf_d_ff    <= trf_s;
			bus_arm_ff  <= nxt_bus_arm;
			dom_to_ff   <= nxt_dom_to;
			rst_hold_ff <= nxt_rst_hold;
			wreq_ff     <= nxt_wreq;
			wsrc_bus_ff <= nxt_wsrc_bus;
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	wire powered = (mode_ff != lsmc_pkg::MODE_UNPOWERED);
	wire nxt_drive = in_normal && !tx_s && !dom_to_ff;
	wire nxt_rx = (!powered || in_sleep) ? 1'b0 :
		(in_pre && wreq_ff) ? 1'b0 : bus_s;
	wire nxt_rstn = powered && !in_sleep && !rst_hold_ff &&
		!uv_s;
	wire nxt_term = in_pre || in_normal;
	wire nxt_reg = powered && !in_sleep;
	wire nxt_txoe = in_pre;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			bus_drive_dom <= 1'b0;
			rx_out        <= 1'b0;
			reset_out_n   <= 1'b0;
			term_en       <= 1'b0;
			reg_en        <= 1'b0;
			tx_oe         <= 1'b0;
			tx_out        <= 1'b0;
		end
		else
		begin
			bus_drive_dom <= nxt_drive;
			rx_out        <= nxt_rx;
			reset_out_n   <= nxt_rstn;
			term_en       <= nxt_term;
			reg_en        <= nxt_reg;
			tx_oe         <= nxt_txoe;
			tx_out        <= wsrc_bus_ff;
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait state per access
	// ----------------------------------------------------------------
	wire        req     = avs_read || avs_write;
	wire        take    = req && avs_waitrequest;
	wire        hit_st  = (avs_address == lsmc_pkg::ADDR_STATUS);
	wire        hit_ctl = (avs_address == lsmc_pkg::ADDR_CTRL);
	wire [31:0] st_word = {24'h000000, dbg_s, rst_hold_ff, wsrc_bus_ff,
		wreq_ff, dom_to_ff, mode_ff};
	wire [31:0] rd_word = hit_st ? st_word :
		hit_ctl ? {30'h00000000, ctrl_ff} : 32'h00000000;
	wire        ctl_wr  = take && avs_write && hit_ctl &&
		avs_byteenable[0];
	wire [1:0]  nxt_ctrl = ctl_wr ? avs_writedata[1:0] : ctrl_ff;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			ctrl_ff         <= lsmc_pkg::CTRL_RESET;
		end
		else
		begin
			avs_waitrequest <= !take;
			avs_readdata    <= (take && avs_read) ? rd_word : avs_readdata;
			ctrl_ff         <= nxt_ctrl;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_dom_force;
		@(posedge core_clk) disable iff (reset)
		dom_to_ff |=> !bus_drive_dom;
	endproperty
	a_dom_force: assert property (p_dom_force)
		else $error("bus driven during dominant timeout");

	property p_dom_clear;
		@(posedge core_clk) disable iff (reset)
		$fell(dom_to_ff) |-> $past(rec_done) && $past(tx_s);
	endproperty
	a_dom_clear: assert property (p_dom_clear)
		else $error("timeout cleared without recessive time");

	property p_rx_normal;
		@(posedge core_clk) disable iff (reset)
		in_normal |=> rx_out == $past(bus_s);
	endproperty
	a_rx_normal: assert property (p_rx_normal)
		else $error("rx_out does not mirror bus");

	property p_normal_tx;
		@(posedge core_clk) disable iff (reset)
		in_normal && !tx_s && !dom_to_ff |=> bus_drive_dom && term_en;
	endproperty
	a_normal_tx: assert property (p_normal_tx)
		else $error("normal mode does not transmit");

	property p_to_silent;
		@(posedge core_clk) disable iff (reset)
		mode_ff == lsmc_pkg::MODE_SELECT && msel_done && tx_s &&
		!en_s && vsp_s |=> in_silent ##1 !bus_drive_dom && !term_en;
	endproperty
	a_to_silent: assert property (p_to_silent)
		else $error("silent mode not entered");

	property p_to_sleep;
		@(posedge core_clk) disable iff (reset)
		mode_ff == lsmc_pkg::MODE_SELECT && msel_done && !tx_s &&
		!en_s && vsp_s |=> in_sleep;
	endproperty
	a_to_sleep: assert property (p_to_sleep)
		else $error("sleep mode not entered");

	property p_sleep_outs;
		@(posedge core_clk) disable iff (reset)
		in_sleep [*2] |-> !reset_out_n && !rx_out && !reg_en && !term_en;
	endproperty
	a_sleep_outs: assert property (p_sleep_outs)
		else $error("sleep outputs not off");

	property p_silent_uv;
		@(posedge core_clk) disable iff (reset)
		in_silent && uv_s && vsp_s |=> in_pre && rst_hold_ff
		##1 !reset_out_n;
	endproperty
	a_silent_uv: assert property (p_silent_uv)
		else $error("silent undervoltage not handled");

	property p_silent_en;
		@(posedge core_clk) disable iff (reset)
		in_silent && en_s && vsp_s && !uv_s && !vsl_s && !bus_wake &&
		!pin_wake |=> in_normal;
	endproperty
	a_silent_en: assert property (p_silent_en)
		else $error("silent to normal not direct");

	property p_pre_hold;
		@(posedge core_clk) disable iff (reset)
		in_pre && vsp_s && (!en_s || rst_hold_ff) |=> in_pre;
	endproperty
	a_pre_hold: assert property (p_pre_hold)
		else $error("pre-normal left early");

	property p_debug;
		@(posedge core_clk) disable iff (reset)
		dbg_s |-> !wd_done;
	endproperty
	a_debug: assert property (p_debug)
		else $error("watchdog active in debug");

	property p_wake_clear;
		@(posedge core_clk) disable iff (reset)
		in_pre && en_s && !rst_hold_ff && vsp_s |=> !wreq_ff ##1
		!tx_oe;
	endproperty
	a_wake_clear: assert property (p_wake_clear)
		else $error("wake flags not cleared");

	c_sleep: cover property (@(posedge core_clk) disable iff (reset)
		in_sleep);
	c_bus_wake: cover property (@(posedge core_clk) disable iff (reset)
		in_sleep ##1 in_pre && wreq_ff && wsrc_bus_ff);
	c_dom: cover property (@(posedge core_clk) disable iff (reset)
		$rose(dom_to_ff));
	c_silent_normal: cover property (@(posedge core_clk)
		disable iff (reset) in_silent ##1 in_normal);

endmodule : lsmc_mode_ctrl

// file: lsmc_host_model.sv
// Host controller model driving the mode, transmit and trigger pins
`timescale 1ns/1ps
module lsmc_host_model (
	// Clock
	input  wire logic core_clk,
	// Controller pins
	output logic      enable,
	output logic      host_tx,
	output logic      trigger_rise,
	output logic      trigger_fall
);
	logic       trig_on;
	logic [4:0] trig_cnt_ff;

	initial
	begin
		enable       = 1'b0;
		host_tx      = 1'b1;
		trigger_rise = 1'b0;
		trigger_fall = 1'b1;
		trig_on      = 1'b1;
		trig_cnt_ff  = 5'h00;
	end

	// --------------------------------------------------------------
	// Watchdog service
	// --------------------------------------------------------------
	// Both trigger pins toggle together, so each kind of edge is seen
	always @(posedge core_clk)
	begin
		trig_cnt_ff <= trig_on ? trig_cnt_ff + 5'h01 : 5'h00;
		if (trig_on && trig_cnt_ff == 5'h1F)
		begin
			trigger_rise <= ~trigger_rise;
			trigger_fall <= ~trigger_fall;
		end
	end

	// --------------------------------------------------------------
	// Pin sequences
	// --------------------------------------------------------------
	task automatic set_trig(input logic v);
		@(posedge core_clk);
		trig_on <= v;
	endtask : set_trig

	task automatic set_en(input logic v);
		@(posedge core_clk);
		enable <= v;
	endtask : set_en

	task automatic set_tx(input logic v);
		@(posedge core_clk);
		host_tx <= v;
	endtask : set_tx

	// Transmit stays high well past the select window
	task automatic go_silent;
		@(posedge core_clk);
		host_tx <= 1'b1;
		enable  <= 1'b0;
		repeat (400) @(posedge core_clk);
	endtask : go_silent

	// Enable falls one cycle after transmit, far inside the limit
	task automatic go_sleep;
		@(posedge core_clk);
		host_tx <= 1'b0;
		@(posedge core_clk);
		enable <= 1'b0;
		repeat (400) @(posedge core_clk);
		host_tx <= 1'b1;
	endtask : go_sleep

	task automatic clear_dom;
		@(posedge core_clk);
		host_tx <= 1'b1;
		repeat (1100) @(posedge core_clk);
	endtask : clear_dom

endmodule : lsmc_host_model

// file: lin_sbc_mode_control_test.sv
// Self-checking testbench of the LIN mode controller
`timescale 1ns/1ps
module lin_sbc_mode_control_test;
	localparam int         DOM_C  = 50;
	localparam int         RST_C  = 40;
	localparam logic [2:0] M_PRE  = lsmc_pkg::MODE_PRENORMAL;
	localparam logic [2:0] M_NORM = lsmc_pkg::MODE_NORMAL;
	localparam logic [2:0] M_SIL  = lsmc_pkg::MODE_SILENT;
	localparam logic [2:0] M_SLP  = lsmc_pkg::MODE_SLEEP;

	logic        core_clk, reset, enable, host_tx, tx_pin, trigger_rise;
	logic        trigger_fall, debug_sel, tx_out, tx_oe, rx_out;
	logic        reset_out_n, bus_lvl, bus_in, wake_n, vs_present, vs_low;
	logic        vdd_undervolt, bus_drive_dom, term_en, reg_en;
	logic [3:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest, tb, bl;
	logic [31:0] avs_writedata, avs_readdata, d, wv;
	logic [3:0]  avs_byteenable, ua;
	logic [1:0]  ce;
	int          err_total, check_count, n;

	// Shared transmit pin and wired-and bus line
	assign tx_pin = tx_oe ? tx_out : host_tx;
	assign bus_in = bus_lvl & ~bus_drive_dom;

	always #5 core_clk = ~core_clk;

	lsmc_host_model host_u (.core_clk(core_clk), .enable(enable),
		.host_tx(host_tx), .trigger_rise(trigger_rise),
		.trigger_fall(trigger_fall));

	lsmc_mode_ctrl #(.DOM_TIMEOUT_CYC(DOM_C), .RESET_DELAY_CYC(RST_C),
		.BUS_WAKE_CYC(10), .PIN_WAKE_CYC(10), .WDOG_CYC(100)) dut_u (
		.core_clk(core_clk), .reset(reset), .enable(enable),
		.tx_in(tx_pin), .trigger_rise(trigger_rise),
		.trigger_fall(trigger_fall), .debug_sel(debug_sel),
		.tx_out(tx_out), .tx_oe(tx_oe), .rx_out(rx_out),
		.reset_out_n(reset_out_n), .bus_in(bus_in), .wake_n(wake_n),
		.vs_present(vs_present), .vs_low(vs_low),
		.vdd_undervolt(vdd_undervolt), .bus_drive_dom(bus_drive_dom),
		.term_en(term_en), .reg_en(reg_en), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// --------------------------------------------------------------
	// Checking and bus tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic av_xfer(input logic wr, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int k;
		k = 0;
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_read      <= !wr;
		avs_write     <= wr;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 50)
		begin
			err_total++;
			$display("[ERR] t=%0t bus wait got=%h exp=%h", $time, 1'b1, 1'b0);
		end
	endtask : av_xfer

	// Polls the mode field; the bound covers the select window
	task automatic wait_mode(input logic [2:0] m);
		int k;
		k = 0;
		do
		begin
			av_xfer(1'b0, lsmc_pkg::ADDR_STATUS, 32'h0, d);
			k++;
		end
		while (d[2:0] !== m && k < 300);
		chk({29'h0, d[2:0]}, {29'h0, m});
	endtask : wait_mode

	task automatic hold(input int c);
		repeat (c) @(posedge core_clk);
	endtask : hold

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	initial
	begin
		{core_clk, reset, bus_lvl, wake_n} = 4'hF;
		{debug_sel, vs_present, vs_low, vdd_undervolt} = 4'h0;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{err_total, check_count} = '0;
		void'($urandom(49));
		hold(16);
		reset <= 1'b0;
		av_xfer(1'b0, lsmc_pkg::ADDR_CTRL, 32'h0, d);
		chk(d, 32'h0000_0003);
		av_xfer(1'b1, lsmc_pkg::ADDR_CTRL, 32'h0, d);
		av_xfer(1'b0, lsmc_pkg::ADDR_CTRL, 32'h0, d);
		chk(d, 32'h0);
		// Random writes: only lane 0 updates the control bits
		ce = 2'h0;
		for (int i = 0; i < 6; i++)
		begin
			wv = $urandom;
			avs_byteenable <= 4'($urandom_range(15, 0));
			av_xfer(1'b1, lsmc_pkg::ADDR_CTRL, wv, d);
			if (avs_byteenable[0])
				ce = wv[1:0];
			ua = 4'($urandom_range(15, 5));
			av_xfer(1'b1, ua, ~wv, d);
			av_xfer(1'b0, ua, 32'h0, d);
			chk(d, 32'h0);
			av_xfer(1'b0, lsmc_pkg::ADDR_CTRL, 32'h0, d);
			chk(d, {30'h0, ce});
		end
		avs_byteenable <= 4'hF;
		av_xfer(1'b1, lsmc_pkg::ADDR_CTRL, 32'h0000_0003, d);
		av_xfer(1'b0, lsmc_pkg::ADDR_CTRL, 32'h0, d);
		chk(d, 32'h0000_0003);
		vs_present <= 1'b1;
		host_u.set_en(1'b1);
		wait_mode(M_PRE);
		chk({reset_out_n, reg_en}, 2'b01);
		hold(10);
		wait_mode(M_PRE);
		wait_mode(M_NORM);
		chk(reset_out_n, 1'b1);
		for (int i = 0; i < 24; i++)
		begin
			tb = 1'($urandom_range(1, 0)) | 1'(i);
			bl = 1'($urandom_range(1, 0));
			host_u.set_tx(tb);
			bus_lvl <= bl;
			// Driver loop back to rx_out takes six edges
			hold(8);
			chk(bus_drive_dom, !tb);
			chk(rx_out, bl & tb);
		end
		bus_lvl <= 1'b1;
		host_u.set_tx(1'b0);
		hold(40);
		chk(bus_drive_dom, 1'b1);
		hold(30);
		chk(bus_drive_dom, 1'b0);
		host_u.set_tx(1'b1);
		hold(900);
		host_u.set_tx(1'b0);
		hold(5);
		chk(bus_drive_dom, 1'b0);
		host_u.clear_dom;
		host_u.set_tx(1'b0);
		hold(5);
		chk(bus_drive_dom, 1'b1);
		host_u.set_tx(1'b1);
		host_u.go_silent;
		wait_mode(M_SIL);
		host_u.set_tx(1'b0);
		hold(5);
		chk({term_en, bus_drive_dom, reg_en}, 3'b001);
		host_u.set_tx(1'b1);
		bus_lvl <= 1'b0;
		hold(20);
		bus_lvl <= 1'b1;
		wait_mode(M_PRE);
		chk({term_en, rx_out, tx_oe, tx_out}, 4'b1011);
		host_u.set_en(1'b1);
		wait_mode(M_NORM);
		chk({30'h0, d[5:4]}, 32'h0);
		host_u.go_silent;
		wait_mode(M_SIL);
		host_u.set_en(1'b1);
		hold(6);
		wait_mode(M_NORM);
		host_u.go_silent;
		vdd_undervolt <= 1'b1;
		hold(6);
		chk(reset_out_n, 1'b0);
		vdd_undervolt <= 1'b0;
		wait_mode(M_PRE);
		host_u.set_en(1'b1);
		wait_mode(M_NORM);
		host_u.go_sleep;
		wait_mode(M_SLP);
		chk({reg_en, term_en, reset_out_n, rx_out}, 4'h0);
		host_u.set_en(1'b1);
		hold(10);
		host_u.set_en(1'b0);
		wait_mode(M_SLP);
		wake_n <= 1'b0;
		hold(20);
		wake_n <= 1'b1;
		wait_mode(M_PRE);
		chk({reg_en, rx_out, tx_oe, tx_out}, 4'b1010);
		host_u.set_en(1'b1);
		wait_mode(M_NORM);
		host_u.go_sleep;
		bus_lvl <= 1'b0;
		hold(20);
		bus_lvl <= 1'b1;
		wait_mode(M_PRE);
		chk({reg_en, term_en, rx_out, tx_out}, 4'b1101);
		host_u.set_en(1'b1);
		wait_mode(M_NORM);
		host_u.go_sleep;
		vs_low <= 1'b1;
		hold(6);
		wait_mode(M_PRE);
		chk(tx_oe, 1'b1);
		vs_low <= 1'b0;
		host_u.set_en(1'b1);
		wait_mode(M_NORM);
		hold(RST_C + 10);
		debug_sel <= 1'b1;
		host_u.set_trig(1'b0);
		hold(300);
		chk(reset_out_n, 1'b1);
		debug_sel <= 1'b0;
		n = 0;
		while (reset_out_n !== 1'b0 && n < 200)
		begin
			hold(1);
			n++;
		end
		chk(reset_out_n, 1'b0);
		host_u.set_trig(1'b1);
		hold(300);
		chk(reset_out_n, 1'b1);
		tally_and_finish;
	end

	// Whole run is near 6000 cycles
	initial
	begin
		hold(60000);
		err_total++;
		$display("[ERR] t=%0t timeout got=%h exp=%h", $time, 1'b1, 1'b0);
		tally_and_finish;
	end

endmodule : lin_sbc_mode_control_test
